// >>> core/tpst_defs.vh
// constants for the tap status, threshold and width-limit block
// Notes on behaviour
// [R01] an axis flag is set only when that axis and tap type are enabled
// [R02] bit 7 reads 1 once an enabled tap raised the interrupt; resets to 0
// [R03] bits 6, 5, 4 flag a tap on z, y, x
// [R04] bit 3 is 1 for a double tap trigger, 0 for single
// [R05] bits 2, 1, 0 give the sign on z, y, x; 1 means negative
// [R06] with latching on, all status bits freeze once bit 7 sets, until read
// [R07] reading the source register clears all eight bits after data returns
// [R08] reading the source register also drops the tap interrupt
// [R09] one 7-bit unsigned threshold per axis, bit 7 reads 0, reset zero
// [R10] threshold codes 1 to 127 always scaled to the widest range
// [R11] detection starts when axis magnitude exceeds its threshold
// [R12] 8-bit width limit bounds time above threshold; only shorter crossings count; the code also counts a width equal to the limit
// [R13] longest width limit is the time step times 255
// [R14] time step depends on sample rate, oversampling mode and tap filter
// [R15] filter on: 1.25 ms at 800 Hz, doubling, capped per mode
// [R16] filter off: steps halve, from 0.625 ms up to 40 ms low power
// [R17] with latching on, flags are held until software reads them
// [R18] with latching off, status follows the newest detection result
// [R19] width counter ticks once per time step and restarts each crossing
`ifndef TPST_DEFS_VH
`define TPST_DEFS_VH
`define TPST_ADDR_SRC 8'h22
`define TPST_ADDR_THR_X 8'h23
`define TPST_ADDR_THR_Y 8'h24
`define TPST_ADDR_THR_Z 8'h25
`define TPST_ADDR_LIMIT 8'h26
`define TPST_RST_SRC 8'h00
`define TPST_RST_THR 7'h00
`define TPST_RST_LIMIT 8'h00
`define TPST_BIT_EVENT 7
`define TPST_BIT_Z_HIT 6
`define TPST_BIT_Y_HIT 5
`define TPST_BIT_X_HIT 4
`define TPST_BIT_DOUBLE 3
`define TPST_BIT_SIGN_Z 2
`define TPST_BIT_SIGN_Y 1
`define TPST_BIT_SIGN_X 0
`define TPST_LIMIT_MAX 8'hFF
`define TPST_CLK_PERIOD_NS 5
`define TPST_STEP_UNIT_NS 625000
`define TPST_STEP_UNIT_CYC (`TPST_STEP_UNIT_NS / `TPST_CLK_PERIOD_NS)
`define TPST_MODE_NORMAL 2'h0
`define TPST_MODE_QUIET 2'h1
`define TPST_MODE_HIRES 2'h2
`define TPST_MODE_LOWPWR 2'h3
`define TPST_FS_2G 2'h0
`define TPST_FS_4G 2'h1
`define TPST_FS_8G 2'h2
`endif

// >>> core/tpst_step_gen.v
// time step tick generator for the tap width counter
`timescale 1ns/1ps
`default_nettype none
module tpst_step_gen #(
    parameter integer UNIT_CYC = 125000
) (
    input wire clock_i,
    input wire nrst_i,
    input wire [3:0] shift_i,
    input wire restart_i,
    output reg tick_o
);
    reg [31:0] cnt_q;
    wire [31:0] span;
    // step length is the unit times a power of two
    assign span = UNIT_CYC << shift_i;
    // free counter, realigned at every new crossing so the first step is whole
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 32'h00000000;
            tick_o <= 1'b0;
        end else if (restart_i || cnt_q >= span - 32'h00000001) begin
            cnt_q <= 32'h00000000;
            tick_o <= ~restart_i;
        end else begin
            cnt_q <= cnt_q + 32'h00000001;
            tick_o <= 1'b0;
        end
    end
endmodule // tpst_step_gen
`default_nettype wire

// >>> core/tpst_axis_det.v
// per-axis threshold compare and width-limit timer
`timescale 1ns/1ps
`default_nettype none
module tpst_axis_det (
    input wire clock_i,
    input wire nrst_i,
    input wire sample_valid_i,
    input wire [11:0] sample_i,
    input wire [6:0] threshold_i,
    input wire [7:0] limit_i,
    input wire step_tick_i,
    output wire start_o,
    output reg tap_o,
    output reg sign_o
);
    reg above_q;
    reg sign_q;
    reg [8:0] width_q;
    wire [11:0] mag;
    wire over;
    // magnitude by two's complement negation; full negative scale gives 2048, still in range
    assign mag = sample_i[11] ? ((~sample_i) + 12'h001) : sample_i;
    // one code is sixteen counts at the widest range; code zero never fires
    assign over = (threshold_i != 7'h00) && (mag[11:4] > {1'b0, threshold_i}); // [R10] [R11]
    assign start_o = sample_valid_i && over && !above_q;
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            above_q <= 1'b0;
            sign_q <= 1'b0;
            width_q <= 9'h000;
            tap_o <= 1'b0;
            sign_o <= 1'b0;
        end else begin
            tap_o <= 1'b0;
            if (start_o) begin
                above_q <= 1'b1;
                sign_q <= sample_i[11];
                width_q <= 9'h000; // [R19]
            end else if (sample_valid_i && above_q && !over) begin
                above_q <= 1'b0;
                tap_o <= (width_q <= {1'b0, limit_i}); // [R12]
                sign_o <= sign_q;
            end else if (step_tick_i && above_q && width_q != 9'h1FF) begin
                width_q <= width_q + 9'h001; // [R19]
            end
        end
    end
endmodule // tpst_axis_det
`default_nettype wire

// >>> core/tpst_core.v
// tap source, threshold and width-limit registers with detection
`timescale 1ns/1ps
`default_nettype none
`include "tpst_defs.vh"
module tpst_core #(
    parameter integer UNIT_CYC = `TPST_STEP_UNIT_CYC
) (
    input wire clock_i,
    input wire nrst_i,
    // register port from the serial interface decoder
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    output reg reg_rvalid_o,
    // samples at the output rate
    input wire sample_valid_i,
    input wire [11:0] sample_x_i,
    input wire [11:0] sample_y_i,
    input wire [11:0] sample_z_i,
    input wire [1:0] full_scale_i,
    // configuration from neighbouring registers
    input wire [5:0] event_enable_i,
    input wire latch_flags_i,
    input wire [2:0] output_sample_rate_i,
    input wire [1:0] oversample_mode_i,
    input wire tap_lowpass_filter_on_i,
    // latency and window timers outside
    input wire latency_busy_i,
    input wire second_window_i,
    output wire tap_end_o,
    output wire tap_irq_o
);
    // register state
    reg [7:0] src_q;
    reg [7:0] src_d;
    reg [6:0] thr_x_q;
    reg [6:0] thr_y_q;
    reg [6:0] thr_z_q;
    reg [7:0] limit_q;
    reg [7:0] rd_mux;

    // samples brought onto the widest range
    wire [11:0] scl_x;
    wire [11:0] scl_y;
    wire [11:0] scl_z;

    // per-axis detector results, bit 0 is x
    wire [2:0] start;
    wire [2:0] tap;
    wire [2:0] sign;

    // shared step clock
    wire step_tick;
    wire [3:0] step_shift;

    // source update terms
    wire src_read;
    wire dbl;
    wire [2:0] hit;
    wire any_hit;
    wire frozen;

    // path of one tap through the block:
    // a sample over threshold starts the axis timer and realigns the step clock;
    // the width counter counts step ticks while the axis stays above;
    // the sample that falls back below ends the crossing;
    // a width within the limit gives a one-cycle tap pulse from the detector;
    // an enabled tap outside latency lands in the source one cycle later;
    // the source event bit is the request, so it stands until read;
    // a read returns the old value and clears the source at the same edge;
    // this costs two cycles from the last sample to the request.

    // bring a sample onto the widest range so thresholds keep fixed weight
    function [11:0] to_wide;
        input [11:0] s;
        input [1:0] fs;
        begin
            // 2 g carries two more fraction bits than 8 g, 4 g one more
            case (fs)
                `TPST_FS_2G: to_wide = {{2{s[11]}}, s[11:2]};
                `TPST_FS_4G: to_wide = {s[11], s[11:1]};
                default: to_wide = s;
            endcase
        end
    endfunction

    // rate code to exponent of the step, before any mode cap
    function [3:0] rate_exp;
        input [2:0] r;
        begin
            // slow rates skip exponents: 12.5 Hz is 64 times slower than 800 Hz
            case (r)
                3'h0: rate_exp = 4'h0;
                3'h1: rate_exp = 4'h1;
                3'h2: rate_exp = 4'h2;
                3'h3: rate_exp = 4'h3;
                3'h4: rate_exp = 4'h4;
                3'h5: rate_exp = 4'h6;
                3'h6: rate_exp = 4'h7;
                default: rate_exp = 4'h9;
            endcase
        end
    endfunction

    // smaller of two exponents
    function [3:0] min4;
        input [3:0] a;
        input [3:0] b;
        begin
            min4 = (a < b) ? a : b;
        end
    endfunction

    // step as a power-of-two multiple of 0.625 ms
    function [3:0] step_exp;
        input [2:0] r;
        input [1:0] m;
        input f;
        reg [3:0] k;
        reg [3:0] km1;
        begin
            k = rate_exp(r);
            // one rate behind, for modes whose unfiltered step lags the rate
            km1 = (k == 4'h0) ? 4'h0 : k - 4'h1;
            if (f) begin
                // filter on: 1.25 ms at the top rate, then capped per mode
                case (m)
                    // normal stops at 20 ms
                    `TPST_MODE_NORMAL: step_exp = min4(k, 4'h4) + 4'h1;
                    // quiet low power stops at 80 ms
                    `TPST_MODE_QUIET: step_exp = min4(k, 4'h6) + 4'h1;
                    // high resolution stops at 2.5 ms
                    `TPST_MODE_HIRES: step_exp = min4(k, 4'h1) + 4'h1;
                    // low power stops at 160 ms
                    default: step_exp = min4(k, 4'h7) + 4'h1;
                endcase
            end else begin
                // filter off: normal and quiet step one rate finer than low power
                case (m)
                    // normal lags one rate, stops at 5 ms
                    `TPST_MODE_NORMAL: step_exp = min4(km1, 4'h3);
                    // quiet lags one rate, stops at 20 ms
                    `TPST_MODE_QUIET: step_exp = min4(km1, 4'h5);
                    // high resolution stays at the unit step
                    `TPST_MODE_HIRES: step_exp = 4'h0;
                    // low power keeps pace, stops at 40 ms
                    default: step_exp = min4(k, 4'h6);
                endcase
            end
        end
    endfunction

    // samples scaled once, shared by compare and sign
    assign scl_x = to_wide(sample_x_i, full_scale_i);
    assign scl_y = to_wide(sample_y_i, full_scale_i);
    assign scl_z = to_wide(sample_z_i, full_scale_i);

    // step length follows rate, mode and filter; longest limit is step times 255
    assign step_shift = step_exp(
        output_sample_rate_i,
        oversample_mode_i,
        tap_lowpass_filter_on_i
    ); // [R13] [R14] [R15] [R16]

    // one shared step clock; a crossing on any axis realigns it
    tpst_step_gen #(
        .UNIT_CYC(UNIT_CYC)
    ) u_step (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .shift_i(step_shift),
        .restart_i(|start),
        .tick_o(step_tick)
    );

    // x axis detector
    tpst_axis_det u_det_x (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .sample_valid_i(sample_valid_i),
        .sample_i(scl_x),
        .threshold_i(thr_x_q),
        .limit_i(limit_q),
        .step_tick_i(step_tick),
        .start_o(start[0]),
        .tap_o(tap[0]),
        .sign_o(sign[0])
    );

    // y axis detector
    tpst_axis_det u_det_y (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .sample_valid_i(sample_valid_i),
        .sample_i(scl_y),
        .threshold_i(thr_y_q),
        .limit_i(limit_q),
        .step_tick_i(step_tick),
        .start_o(start[1]),
        .tap_o(tap[1]),
        .sign_o(sign[1])
    );

    // z axis detector
    tpst_axis_det u_det_z (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .sample_valid_i(sample_valid_i),
        .sample_i(scl_z),
        .threshold_i(thr_z_q),
        .limit_i(limit_q),
        .step_tick_i(step_tick),
        .start_o(start[2]),
        .tap_o(tap[2]),
        .sign_o(sign[2])
    );

    // an axis reports only for its own enable of the tap type seen
    function axis_hit;
        input t;
        input d;
        input en_single;
        input en_double;
        input blocked;
        begin
            axis_hit = t && !blocked && (d ? en_double : en_single); // [R01]
        end
    endfunction

    // a tap inside the second window counts as double; latency hides pulses
    assign dbl = second_window_i;
    assign hit[0] = axis_hit(tap[0], dbl, event_enable_i[0], event_enable_i[1], latency_busy_i); // [R01]
    assign hit[1] = axis_hit(tap[1], dbl, event_enable_i[2], event_enable_i[3], latency_busy_i); // [R01]
    assign hit[2] = axis_hit(tap[2], dbl, event_enable_i[4], event_enable_i[5], latency_busy_i); // [R01]
    assign any_hit = |hit;
    // every valid crossing end outside latency goes to the latency timer, enabled or not
    assign tap_end_o = (|tap) && !latency_busy_i;

    // a read strobe on the source address
    assign src_read = reg_rd_i && (reg_addr_i == `TPST_ADDR_SRC);

    // latched flags stand still while the event bit is up
    assign frozen = latch_flags_i && src_q[`TPST_BIT_EVENT];

    // next source value: read clears, then a new event lands on top
    always @* begin
        src_d = src_q;
        if (src_read) begin
            src_d = `TPST_RST_SRC; // [R07]
        end
        // an event and a read at one edge: the event survives the clear
        if (any_hit && (!frozen || src_read)) begin
            // latched: first event wins; unlatched: newest event replaces
            src_d[`TPST_BIT_EVENT] = 1'b1; // [R02] [R06] [R17] [R18]
            src_d[`TPST_BIT_Z_HIT] = hit[2]; // [R03]
            src_d[`TPST_BIT_Y_HIT] = hit[1]; // [R03]
            src_d[`TPST_BIT_X_HIT] = hit[0]; // [R03]
            src_d[`TPST_BIT_DOUBLE] = dbl; // [R04]
            // signs only for axes that hit, so a quiet axis reads positive
            src_d[`TPST_BIT_SIGN_Z] = hit[2] & sign[2]; // [R05]
            src_d[`TPST_BIT_SIGN_Y] = hit[1] & sign[1]; // [R05]
            src_d[`TPST_BIT_SIGN_X] = hit[0] & sign[0]; // [R05]
        end
    end

    // source register
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            src_q <= `TPST_RST_SRC; // [R02]
        end else begin
            src_q <= src_d;
        end
    end

    // interrupt request is the event bit, so a read drops it
    // a level, not a pulse: a host that misses the edge still sees it
    assign tap_irq_o = src_q[`TPST_BIT_EVENT]; // [R08]

    // x threshold; seven bits stored, the top bit reads back as zero
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            thr_x_q <= `TPST_RST_THR;
        end else if (reg_wr_i && (reg_addr_i == `TPST_ADDR_THR_X)) begin
            thr_x_q <= reg_wdata_i[6:0]; // [R09]
        end
    end

    // y threshold
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            thr_y_q <= `TPST_RST_THR;
        end else if (reg_wr_i && (reg_addr_i == `TPST_ADDR_THR_Y)) begin
            thr_y_q <= reg_wdata_i[6:0]; // [R09]
        end
    end

    // z threshold
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            thr_z_q <= `TPST_RST_THR;
        end else if (reg_wr_i && (reg_addr_i == `TPST_ADDR_THR_Z)) begin
            thr_z_q <= reg_wdata_i[6:0]; // [R09]
        end
    end

    // width limit; all eight bits count
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            limit_q <= `TPST_RST_LIMIT;
        end else if (reg_wr_i && (reg_addr_i == `TPST_ADDR_LIMIT)) begin
            limit_q <= reg_wdata_i; // [R12]
        end
    end

    // read select; the source register is read only, writes to it are dropped
    // unmapped addresses read as zero
    always @* begin
        case (reg_addr_i)
            `TPST_ADDR_SRC: rd_mux = src_q;
            `TPST_ADDR_THR_X: rd_mux = {1'b0, thr_x_q}; // [R09]
            `TPST_ADDR_THR_Y: rd_mux = {1'b0, thr_y_q}; // [R09]
            `TPST_ADDR_THR_Z: rd_mux = {1'b0, thr_z_q}; // [R09]
            `TPST_ADDR_LIMIT: rd_mux = limit_q;
            default: rd_mux = 8'h00;
        endcase
    end

    // read data registered; it carries the value from before the clear
    // valid follows every read strobe, whatever the address
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rd_mux; // [R07]
            end
        end
    end
endmodule // tpst_core
`default_nettype wire

// >>> tb/tpst_host.sv
// host side register master for the tap status block
`timescale 1ns/1ps
`default_nettype none
module tpst_host (
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    output logic rd_o
);
    // idle bus at time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // one-cycle write strobe; address and data are scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clock_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    // read data is only trusted while its valid pulse stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clock_i);
        rd_o = 1'b0;
        addr_o = ~a;
        d = rvalid_i ? rdata_i : 8'hXX;
    endtask
endmodule // tpst_host
`default_nettype wire

// >>> tb/tpst_core_sva.sv
// port-level assertions for the tap status block
`timescale 1ns/1ps
`default_nettype none
module tpst_core_sva #(
    parameter integer UNIT_CYC = 4
) (
    input wire clock_i,
    input wire nrst_i,
    input wire [7:0] reg_addr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire reg_rvalid_o,
    input wire sample_valid_i,
    input wire tap_end_o,
    input wire tap_irq_o
);
    default clocking dclk @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);
    // a source read with no new event landing at the same edge
    sequence src_read_quiet;
        reg_rd_i && reg_addr_i == 8'h22 && !tap_end_o;
    endsequence
    sequence thr_read;
        reg_rd_i && reg_addr_i >= 8'h23 && reg_addr_i <= 8'h25;
    endsequence
    chk_valid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("read valid without a read strobe");
    chk_rdata_holds: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    chk_irq_is_bit7: assert property (reg_rd_i && reg_addr_i == 8'h22 |=> reg_rdata_o[7] == $past(tap_irq_o))
        else $error("source bit 7 differs from interrupt");
    chk_irq_cause: assert property ($rose(tap_irq_o) |-> $past(tap_end_o))
        else $error("interrupt rose without a tap end");
    chk_irq_holds: assert property (tap_irq_o && !(reg_rd_i && reg_addr_i == 8'h22) |=> tap_irq_o)
        else $error("interrupt dropped without a source read");
    chk_read_drops_irq: assert property (src_read_quiet |=> !tap_irq_o)
        else $error("interrupt still high after source read");
    chk_read_clears: assert property (src_read_quiet ##1 !tap_end_o ##1 src_read_quiet |=> reg_rdata_o == 8'h00)
        else $error("source not cleared by previous read");
    chk_end_after_sample: assert property (tap_end_o |-> $past(sample_valid_i))
        else $error("tap end without a sample one cycle before");
    chk_thr_top_zero: assert property (thr_read |=> !reg_rdata_o[7])
        else $error("threshold bit 7 read as one");
    chk_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < 8'h22 || reg_addr_i > 8'h26) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read returned nonzero");
endmodule // tpst_core_sva
bind tpst_core tpst_core_sva #(.UNIT_CYC(UNIT_CYC)) tpst_core_sva_i (.clock_i(clock_i), .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .sample_valid_i(sample_valid_i), .tap_end_o(tap_end_o), .tap_irq_o(tap_irq_o));
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the tap status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [2:0] r;
        logic [1:0] m, fs, ax;
        logic f, dbl;
        logic [5:0] en;
        logic [11:0] smp;
        logic [9:0] w;
        logic [7:0] lim, exp;
    } tpst_row_t;
    // rate, mode, scale, axis, filter, double, enables, sample, width, limit, source
    tpst_row_t rows [14] = '{
        '{3'h0, 2'h0, 2'h2, 2'h0, 1'b1, 1'b0, 6'h01, 12'h0B0, 10'h003, 8'h00, 8'h90},
        '{3'h0, 2'h0, 2'h2, 2'h0, 1'b1, 1'b0, 6'h01, 12'hF50, 10'h003, 8'h00, 8'h91},
        '{3'h0, 2'h0, 2'h2, 2'h0, 1'b1, 1'b0, 6'h01, 12'h0A1, 10'h003, 8'h00, 8'h00},
        '{3'h0, 2'h0, 2'h2, 2'h0, 1'b1, 1'b0, 6'h02, 12'h0B0, 10'h003, 8'h00, 8'h00},
        '{3'h0, 2'h0, 2'h2, 2'h1, 1'b1, 1'b0, 6'h04, 12'hF50, 10'h003, 8'h00, 8'hA2},
        '{3'h0, 2'h0, 2'h2, 2'h2, 1'b1, 1'b1, 6'h20, 12'hF50, 10'h003, 8'h00, 8'hCC},
        '{3'h0, 2'h0, 2'h0, 2'h0, 1'b1, 1'b0, 6'h01, 12'h2C0, 10'h003, 8'h00, 8'h90},
        '{3'h0, 2'h0, 2'h0, 2'h0, 1'b1, 1'b0, 6'h01, 12'h0B0, 10'h003, 8'h00, 8'h00},
        '{3'h0, 2'h0, 2'h2, 2'h0, 1'b1, 1'b0, 6'h01, 12'h0B0, 10'h005, 8'h00, 8'h90},
        '{3'h0, 2'h0, 2'h2, 2'h0, 1'b0, 1'b0, 6'h01, 12'h0B0, 10'h005, 8'h00, 8'h00},
        '{3'h7, 2'h0, 2'h2, 2'h0, 1'b1, 1'b0, 6'h01, 12'h0B0, 10'h017, 8'h00, 8'h90},
        '{3'h7, 2'h2, 2'h2, 2'h0, 1'b1, 1'b0, 6'h01, 12'h0B0, 10'h017, 8'h00, 8'h00},
        '{3'h6, 2'h3, 2'h2, 2'h0, 1'b1, 1'b0, 6'h01, 12'h0B0, 10'h257, 8'h01, 8'h90},
        '{3'h6, 2'h3, 2'h2, 2'h0, 1'b0, 1'b0, 6'h01, 12'h0B0, 10'h257, 8'h01, 8'h00}
    };
    logic clock_i = 1'b0;
    logic nrst = 1'b0, sv = 1'b0, latch = 1'b1, filt = 1'b1, busy = 1'b0, win = 1'b0;
    logic [11:0] sx = 12'h000, sy = 12'h000, sz = 12'h000;
    logic [1:0] fs = 2'h2, mode = 2'h0;
    logic [2:0] rate = 3'h0;
    logic [5:0] en = 6'h00;
    wire [7:0] addr, wd, rdata;
    wire wr, rd, rvalid, tend, irq;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [7:0] n_end = 8'h00;
    // tally of crossing-end pulses, counted at the edge where each one stands
    always @(posedge clock_i) begin
        if (tend === 1'b1) begin
            n_end <= n_end + 8'h01;
        end
    end
    // 200 MHz clock
    always #2.5 clock_i = ~clock_i;
    // short step unit keeps the long width limits affordable
    tpst_core #(.UNIT_CYC(4)) tpst_core_i (
        .clock_i(clock_i), .nrst_i(nrst), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .sample_valid_i(sv), .sample_x_i(sx), .sample_y_i(sy),
        .sample_z_i(sz), .full_scale_i(fs), .event_enable_i(en), .latch_flags_i(latch),
        .output_sample_rate_i(rate), .oversample_mode_i(mode), .tap_lowpass_filter_on_i(filt),
        .latency_busy_i(busy), .second_window_i(win), .tap_end_o(tend), .tap_irq_o(irq));
    tpst_host tpst_host_i (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr), .wr_o(wr),
        .wdata_o(wd), .rd_o(rd));
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        tpst_host_i.rd(a, d);
        check(nm, e, d);
    endtask
    task automatic do_reset;
        @(negedge clock_i);
        nrst = 1'b0;
        repeat (10) @(negedge clock_i);
        nrst = 1'b1;
    endtask
    // one crossing on one axis, held w cycles between the two samples
    task automatic tap(input logic [1:0] ax, input logic [11:0] s, input logic [9:0] w);
        @(negedge clock_i);
        sx = (ax == 2'h0) ? s : 12'h000;
        sy = (ax == 2'h1) ? s : 12'h000;
        sz = (ax == 2'h2) ? s : 12'h000;
        sv = 1'b1;
        @(negedge clock_i);
        sv = 1'b0;
        repeat (w) @(negedge clock_i);
        {sx, sy, sz} = 36'h0;
        sv = 1'b1;
        @(negedge clock_i);
        sv = 1'b0;
        repeat (3) @(negedge clock_i);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 10k cycles
    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        do_reset();
        foreach (rows[i]) begin
            {rate, mode, fs, filt, en, win} = {rows[i].r, rows[i].m, rows[i].fs, rows[i].f, rows[i].en, rows[i].dbl};
            for (int k = 0; k < 3; k++) tpst_host_i.wr(8'h23 + k[7:0], 8'h0A);
            tpst_host_i.wr(8'h26, rows[i].lim);
            tap(rows[i].ax, rows[i].smp, rows[i].w);
            check("irq", {7'h00, rows[i].exp[7]}, {7'h00, irq});
            rdchk("source", 8'h22, rows[i].exp);
            $display("row %0d done", i);
        end
        // every valid crossing end pulses, enabled or not: rows 0,1,3,4,5,6,8,10,12
        check("tap_ends", 8'h09, n_end);
        // register map edges: top threshold bit, full limit, read-only source, unmapped
        tpst_host_i.wr(8'h23, 8'hFF);
        rdchk("thr_x", 8'h23, 8'h7F);
        tpst_host_i.wr(8'h26, 8'hFF);
        rdchk("limit", 8'h26, 8'hFF);
        tpst_host_i.wr(8'h22, 8'h55);
        rdchk("src_ro", 8'h22, 8'h00);
        rdchk("unmapped", 8'h27, 8'h00);
        $display("register test done");
        // latched: second event must not disturb the first until read
        tpst_host_i.wr(8'h23, 8'h0A);
        {rate, mode, fs, filt, en, win} = {3'h0, 2'h0, 2'h2, 1'b1, 6'h3F, 1'b0};
        tap(2'h0, 12'h0B0, 10'h003);
        tap(2'h1, 12'hF50, 10'h003);
        rdchk("latched", 8'h22, 8'h90);
        rdchk("cleared", 8'h22, 8'h00);
        check("irq_clr", 8'h00, {7'h00, irq});
        latch = 1'b0;
        tap(2'h0, 12'h0B0, 10'h003);
        tap(2'h1, 12'hF50, 10'h003);
        rdchk("newest", 8'h22, 8'hA2);
        $display("latch test done");
        // code zero disables an axis; latency window drops taps
        tpst_host_i.wr(8'h23, 8'h00);
        tap(2'h0, 12'h7FF, 10'h003);
        rdchk("thr_zero", 8'h22, 8'h00);
        busy = 1'b1;
        tap(2'h1, 12'hF50, 10'h003);
        rdchk("busy", 8'h22, 8'h00);
        // four latch-test ends added; code zero and latency add none
        check("tap_ends_refused", 8'h0D, n_end);
        busy = 1'b0;
        $display("refusal test done");
        // reset in mid-run with an event pending
        latch = 1'b1;
        tap(2'h1, 12'hF50, 10'h003);
        do_reset();
        check("irq_rst", 8'h00, {7'h00, irq});
        for (int k = 0; k < 5; k++) rdchk("reset_val", 8'h22 + k[7:0], 8'h00);
        $display("reset test done");
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
